//--- logic/hsc_cmd_pkg.sv
// constants for the counter command checker
package hsc_cmd_pkg;
  // widths
  localparam int CNT_W = 24;
  // command selector codes
  localparam logic [7:0] CMD_DISCRETE = 8'h00;
  localparam logic [7:0] CMD_RESET    = 8'h01;
  localparam logic [7:0] CMD_HOME     = 8'h04;
  localparam logic [7:0] CMD_CLR_PU   = 8'h06;
  localparam logic [7:0] CMD_UCL      = 8'h21;
  localparam logic [7:0] CMD_LCL      = 8'h22;
  localparam logic [7:0] CMD_TBASE    = 8'h23;
  localparam logic [7:0] CMD_OUT_PRE  = 8'h24;
  localparam logic [7:0] CMD_INT_PRE  = 8'h28;
  localparam logic [7:0] CMD_LOAD_ACC = 8'h20;
  // error numbers
  localparam logic [7:0] ERR_NONE     = 8'h00;
  localparam logic [7:0] ERR_HOME     = 8'h01;
  localparam logic [7:0] ERR_OUT_PRE  = 8'h07;
  localparam logic [7:0] ERR_INT_PRE  = 8'h0B;
  localparam logic [7:0] ERR_ACC      = 8'h13;
  localparam logic [7:0] ERR_UCL      = 8'h14;
  localparam logic [7:0] ERR_LCL      = 8'h15;
  localparam logic [7:0] ERR_TBASE    = 8'h16;
  localparam logic [7:0] ERR_PU       = 8'h17;
  localparam logic [7:0] ERR_IRAM     = 8'h18;
  localparam logic [7:0] ERR_XRAM     = 8'h19;
  localparam logic [7:0] ERR_ROM      = 8'h1A;
  localparam logic [7:0] ERR_SUPPLY   = 8'h1B;
  // limits
  localparam logic signed [24:0] UCL_MIN_SPAN = 25'sh0000080;
  localparam logic signed [24:0] LCL_MIN_SPAN = 25'sh000007F;
  localparam logic [23:0] TBASE_MIN = 24'h000001;
  localparam logic [23:0] TBASE_MAX = 24'h00FFFF;
  localparam logic [23:0] LCL_RESET = 24'h800000;
  localparam logic [23:0] UCL_RESET = 24'h7FFFFF;
  localparam logic [23:0] TBASE_RESET = 24'h000001;
  // status byte fields
  localparam int SB_HEART = 0;
  localparam int SB_PU    = 1;
  localparam int SB_EXT   = 2;
  localparam int SB_CNTEN = 3;
  localparam int SB_HOME  = 4;
  localparam int SB_TYPE  = 5;
  localparam logic [2:0] TYPE_ACC = 3'h0;
  localparam logic [2:0] TYPE_ERR = 3'h4;
  // discrete data bits
  localparam int DSC_OUT_EN = 0;
  localparam int DSC_CNT_EN = 1;
  // homing states
  typedef enum logic [2:0] {
    HOME_IDLE   = 3'b001,
    HOME_LIMIT  = 3'b010,
    HOME_MARKER = 3'b100
  } home_state_t;
endpackage

//--- logic/hsc_cmd_check.sv
// command validation, error reporting and homing for the counter
`timescale 1ns/100ps
module hsc_cmd_check #(
  parameter int CNT_W = hsc_cmd_pkg::CNT_W
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // scan exchange from host
  input  wire logic             scan_strobe,
  input  wire logic [7:0]       command_selector,
  input  wire logic [CNT_W-1:0] cmd_data,
  // field inputs
  input  wire logic             count_pulse,
  input  wire logic             count_down,
  input  wire logic             limit_input,
  input  wire logic             marker_input,
  // health inputs
  input  wire logic             iram_fail,
  input  wire logic             xram_fail,
  input  wire logic             rom_fail,
  input  wire logic             ext_supply_bad,
  // answer to host
  output logic [7:0]            status_byte_field,
  output logic [CNT_W-1:0]      returned_data_bytes,
  output logic                  outputs_enabled
);

  if (CNT_W != 24) begin : g_width_check
    $error("CNT_W must be 24");
  end

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic signed [23:0] v,
                                    input logic signed [23:0] lo,
                                    input logic signed [23:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic signed [23:0]      lcl_r;
  logic signed [23:0]      ucl_r;
  logic signed [23:0]      accum_r;
  logic signed [23:0]      home_val_r;
  logic        [23:0]      tbase_r;
  logic signed [23:0]      out_pre_r [4];
  logic signed [23:0]      int_pre_r [8];
  logic                    pu_flag_r;
  logic                    heart_r;
  logic                    dead_r;
  logic                    home_est_r;
  logic                    cnt_en_r;
  logic                    supply_d_r;
  logic [7:0]              pend_r;
  hsc_cmd_pkg::home_state_t home_r;

  // ----------------------------------------------------------------
  // command decode and checks
  // ----------------------------------------------------------------
  wire logic signed [23:0] dval     = cmd_data;
  wire logic [7:0]         cmd      = command_selector;
  wire logic               is_out   = (cmd[7:2] ==
                                       hsc_cmd_pkg::CMD_OUT_PRE[7:2]);
  wire logic               is_int   = (cmd[7:3] ==
                                       hsc_cmd_pkg::CMD_INT_PRE[7:3]);
  wire logic               dval_ok  = in_range(dval, lcl_r, ucl_r);
  wire logic signed [24:0] ucl_span = {dval[23], dval} -
                                      {lcl_r[23], lcl_r};
  wire logic signed [24:0] lcl_span = {ucl_r[23], ucl_r} -
                                      {dval[23], dval};
  wire logic               pu_exempt = (cmd == hsc_cmd_pkg::CMD_RESET) ||
                                       (cmd == hsc_cmd_pkg::CMD_CLR_PU);
  wire logic               supply_rise = ext_supply_bad && !supply_d_r;
  wire logic               diag_fail = iram_fail || xram_fail || rom_fail;
  logic [7:0]              cmd_err;

  always_comb begin
    cmd_err = hsc_cmd_pkg::ERR_NONE;
    if (pu_flag_r && !pu_exempt) begin
      cmd_err = hsc_cmd_pkg::ERR_PU;
    end else if (cmd == hsc_cmd_pkg::CMD_HOME) begin
      if (!dval_ok) cmd_err = hsc_cmd_pkg::ERR_HOME;
    end else if (is_out) begin
      if (!dval_ok) cmd_err = hsc_cmd_pkg::ERR_OUT_PRE + {6'h00, cmd[1:0]};
    end else if (is_int) begin
      if (!dval_ok) cmd_err = hsc_cmd_pkg::ERR_INT_PRE + {5'h00, cmd[2:0]};
    end else if (cmd == hsc_cmd_pkg::CMD_LOAD_ACC) begin
      if (!dval_ok) cmd_err = hsc_cmd_pkg::ERR_ACC;
    end else if (cmd == hsc_cmd_pkg::CMD_UCL) begin
      if (ucl_span < hsc_cmd_pkg::UCL_MIN_SPAN) cmd_err = hsc_cmd_pkg::ERR_UCL;
    end else if (cmd == hsc_cmd_pkg::CMD_LCL) begin
      if (lcl_span < hsc_cmd_pkg::LCL_MIN_SPAN) cmd_err = hsc_cmd_pkg::ERR_LCL;
    end else if (cmd == hsc_cmd_pkg::CMD_TBASE) begin
      if (cmd_data < hsc_cmd_pkg::TBASE_MIN ||
          cmd_data > hsc_cmd_pkg::TBASE_MAX)
        cmd_err = hsc_cmd_pkg::ERR_TBASE;
    end
  end

  wire logic       run_cmd  = scan_strobe && !dead_r &&
                              (cmd_err == hsc_cmd_pkg::ERR_NONE);
  wire logic       do_reset = supply_rise ||
                              (run_cmd && cmd == hsc_cmd_pkg::CMD_RESET);
  wire logic [7:0] diag_code = iram_fail ? hsc_cmd_pkg::ERR_IRAM :
                               xram_fail ? hsc_cmd_pkg::ERR_XRAM :
                                           hsc_cmd_pkg::ERR_ROM;
  wire logic [7:0] scan_err = (pend_r != hsc_cmd_pkg::ERR_NONE) ? pend_r :
                              (dead_r ? hsc_cmd_pkg::ERR_NONE : cmd_err);
  wire logic       homing   = (home_r != hsc_cmd_pkg::HOME_IDLE);
  wire logic       count_go = count_pulse && cnt_en_r && !homing && !dead_r;
  wire logic       true_home = (home_r == hsc_cmd_pkg::HOME_MARKER) &&
                               marker_input;

  // ----------------------------------------------------------------
  // pending event errors and health
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pend_r     <= hsc_cmd_pkg::ERR_NONE;
      dead_r     <= 1'b0;
      supply_d_r <= 1'b0;
      heart_r    <= 1'b0;
    end else begin
      supply_d_r <= ext_supply_bad;
      if (diag_fail && !dead_r) begin
        dead_r <= 1'b1;
        pend_r <= diag_code;
      end else if (supply_rise) begin
        pend_r <= hsc_cmd_pkg::ERR_SUPPLY;
      end else if (scan_strobe) begin
        pend_r <= hsc_cmd_pkg::ERR_NONE;
      end
      if (scan_strobe && !dead_r) heart_r <= !heart_r;
    end
  end

  // ----------------------------------------------------------------
  // configuration and power-up flag
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lcl_r     <= hsc_cmd_pkg::LCL_RESET;
      ucl_r     <= hsc_cmd_pkg::UCL_RESET;
      tbase_r   <= hsc_cmd_pkg::TBASE_RESET;
      pu_flag_r <= 1'b1;
      cnt_en_r  <= 1'b0;
      out_pre_r <= '{default: '0};
      int_pre_r <= '{default: '0};
    end else if (do_reset) begin
      lcl_r     <= hsc_cmd_pkg::LCL_RESET;
      ucl_r     <= hsc_cmd_pkg::UCL_RESET;
      tbase_r   <= hsc_cmd_pkg::TBASE_RESET;
      pu_flag_r <= 1'b1;
      cnt_en_r  <= 1'b0;
      out_pre_r <= '{default: '0};
      int_pre_r <= '{default: '0};
    end else if (run_cmd) begin
      if (cmd == hsc_cmd_pkg::CMD_CLR_PU) pu_flag_r <= 1'b0;
      if (cmd == hsc_cmd_pkg::CMD_UCL) ucl_r <= dval;
      if (cmd == hsc_cmd_pkg::CMD_LCL) lcl_r <= dval;
      if (cmd == hsc_cmd_pkg::CMD_TBASE) tbase_r <= cmd_data;
      if (is_out) out_pre_r[cmd[1:0]] <= dval;
      if (is_int) int_pre_r[cmd[2:0]] <= dval;
      if (cmd == hsc_cmd_pkg::CMD_DISCRETE)
        cnt_en_r <= cmd_data[hsc_cmd_pkg::DSC_CNT_EN];
    end
  end

  // ----------------------------------------------------------------
  // homing, accumulator, outputs enable
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      home_r          <= hsc_cmd_pkg::HOME_IDLE;
      home_val_r      <= '0;
      home_est_r      <= 1'b0;
      accum_r         <= '0;
      outputs_enabled <= 1'b0;
    end else if (do_reset) begin
      home_r          <= hsc_cmd_pkg::HOME_IDLE;
      home_est_r      <= 1'b0;
      accum_r         <= '0;
      outputs_enabled <= 1'b0;
    end else begin
      if (run_cmd && cmd == hsc_cmd_pkg::CMD_HOME) begin
        home_r          <= hsc_cmd_pkg::HOME_LIMIT;
        home_val_r      <= dval;
        home_est_r      <= 1'b0;
        outputs_enabled <= 1'b0;
      end else begin
        case (home_r)
          hsc_cmd_pkg::HOME_IDLE: begin
            home_r <= hsc_cmd_pkg::HOME_IDLE;
          end
          hsc_cmd_pkg::HOME_LIMIT: begin
            if (limit_input) home_r <= hsc_cmd_pkg::HOME_MARKER;
          end
          hsc_cmd_pkg::HOME_MARKER: begin
            if (marker_input) home_r <= hsc_cmd_pkg::HOME_IDLE;
          end
          default: begin
            home_r <= hsc_cmd_pkg::HOME_IDLE;
          end
        endcase
        if (run_cmd && cmd == hsc_cmd_pkg::CMD_DISCRETE)
          outputs_enabled <= cmd_data[hsc_cmd_pkg::DSC_OUT_EN];
      end
      if (true_home) begin
        accum_r <= home_val_r;
      end else if (run_cmd && cmd == hsc_cmd_pkg::CMD_LOAD_ACC) begin
        accum_r <= dval;
      end else if (count_go) begin
        accum_r <= count_down ? accum_r - 24'sh000001 :
                                accum_r + 24'sh000001;
      end
      if (true_home || (run_cmd && cmd == hsc_cmd_pkg::CMD_LOAD_ACC))
        home_est_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // returned status and data
  // ----------------------------------------------------------------
  wire logic       err_now  = (scan_err != hsc_cmd_pkg::ERR_NONE);
  wire logic [2:0] type_nxt = err_now ? hsc_cmd_pkg::TYPE_ERR :
                                        hsc_cmd_pkg::TYPE_ACC;

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      status_byte_field   <= 8'h02;
      returned_data_bytes <= '0;
    end else if (scan_strobe) begin
      status_byte_field <= {type_nxt, home_est_r, cnt_en_r, ext_supply_bad,
                            pu_flag_r || do_reset,
                            dead_r ? heart_r : !heart_r};
      returned_data_bytes <= err_now ? {16'h0000, scan_err} : accum_r;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_r);

  a_err_type_code: assert property (
    scan_strobe && !dead_r && pend_r == 8'h00 && cmd_err != 8'h00 |=>
      status_byte_field[7:5] == 3'h4 &&
      returned_data_bytes[7:0] == $past(cmd_err))
    else $error("error type or number wrong");
  a_err_one_scan: assert property (
    scan_strobe && status_byte_field[7:5] == 3'h4 && pend_r == 8'h00 &&
    cmd_err == 8'h00 && !diag_fail && !supply_rise |=>
      status_byte_field[7:5] == 3'h0)
    else $error("error not cleared next scan");
  a_err_no_exec: assert property (
    scan_strobe && cmd_err != 8'h00 && !supply_rise |=>
      $stable(lcl_r) && $stable(ucl_r) && $stable(cnt_en_r))
    else $error("rejected command changed state");
  a_err_upper_zero: assert property (
    status_byte_field[7:5] == 3'h4 |-> returned_data_bytes[23:8] == 16'h0000)
    else $error("upper bytes not zero");
  a_home_range: assert property (
    !pu_flag_r && cmd == 8'h04 && !in_range(dval, lcl_r, ucl_r) |->
      cmd_err == 8'h01)
    else $error("home range not checked");
  a_out_pre_code: assert property (
    !pu_flag_r && is_out && !dval_ok |-> cmd_err == 8'h07 + {6'h00, cmd[1:0]})
    else $error("output preset error wrong");
  a_int_pre_code: assert property (
    !pu_flag_r && is_int && !dval_ok |-> cmd_err == 8'h0B + {5'h00, cmd[2:0]})
    else $error("internal preset error wrong");
  a_acc_code: assert property (
    !pu_flag_r && cmd == 8'h20 && !dval_ok |-> cmd_err == 8'h13)
    else $error("accumulate error wrong");
  a_ucl_span: assert property (
    scan_strobe && !dead_r && !pu_flag_r && cmd == 8'h21 && ucl_span < 128
    && !supply_rise |=> $stable(ucl_r))
    else $error("narrow upper limit accepted");
  a_lcl_span: assert property (
    !pu_flag_r && cmd == 8'h22 && lcl_span < 127 |-> cmd_err == 8'h15)
    else $error("narrow lower limit accepted");
  a_tbase_rng: assert property (
    !pu_flag_r && cmd == 8'h23 && cmd_data == 24'h000000 |-> cmd_err == 8'h16)
    else $error("zero time base accepted");
  a_pu_lock: assert property (
    pu_flag_r && cmd == 8'h20 |-> cmd_err == 8'h17)
    else $error("command ran under power-up");
  a_heart_dead: assert property (
    dead_r && scan_strobe |=> $stable(status_byte_field[0]))
    else $error("heartbeat toggled after failure");
  a_supply_fault: assert property (
    supply_rise && !diag_fail |=> pu_flag_r && pend_r == 8'h1B)
    else $error("supply fault not handled");
  a_home_quiet: assert property (
    homing && !true_home |=> !outputs_enabled && ($stable(accum_r) ||
      $past(run_cmd) || $past(do_reset)))
    else $error("homing let outputs or counts through");
  a_home_load: assert property (
    true_home && !do_reset |=> accum_r == $past(home_val_r) && home_est_r
      ##1 home_r == hsc_cmd_pkg::HOME_IDLE)
    else $error("true home did not load");
  a_home_seq: assert property (
    home_r == hsc_cmd_pkg::HOME_LIMIT && !limit_input && !do_reset &&
    !run_cmd |=> home_r == hsc_cmd_pkg::HOME_LIMIT)
    else $error("homing skipped limit");

  c_error_seen: cover property (status_byte_field[7:5] == 3'h4);
  c_home_done:  cover property (true_home);
  c_dead:       cover property (dead_r && scan_strobe);
  c_pu_clear:   cover property (run_cmd && cmd == 8'h06);

endmodule // hsc_cmd_check

//--- dv/host_cpu_model.sv
// host controller model that issues one command per scan
`timescale 1ns/100ps
module host_cpu_model (
  // clock
  input  wire logic        sys_clk,
  // scan exchange
  output logic             scan_strobe,
  output logic [7:0]       command_selector,
  output logic [23:0]      cmd_data,
  input  wire logic [7:0]  status_byte_field,
  input  wire logic [23:0] returned_data_bytes
);
  initial begin
    scan_strobe      = 1'b0;
    command_selector = 8'hFF;
    cmd_data         = 24'h000000;
  end

  // one scan: drive, hold through the taking edge, read the answer
  task automatic scan(input logic [7:0] c, input logic [23:0] d,
                      output logic [7:0] st, output logic [23:0] dat);
    @(posedge sys_clk);
    #2;
    scan_strobe      = 1'b1;
    command_selector = c;
    cmd_data         = d;
    @(posedge sys_clk);
    #2;
    st  = status_byte_field;
    dat = returned_data_bytes;
    // released lines no longer hold the last value
    scan_strobe      = 1'b0;
    command_selector = ~c;
    cmd_data         = ~d;
  endtask
endmodule // host_cpu_model

//--- dv/testbench.sv
// self-checking bench for the counter command checker
`timescale 1ns/100ps
module testbench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        sys_clk;
  logic        resetn;
  logic        count_pulse;
  logic        count_down;
  logic        limit_input;
  logic        marker_input;
  logic        iram_fail;
  logic        xram_fail;
  logic        rom_fail;
  logic        ext_supply_bad;
  logic        scan_strobe;
  logic [7:0]  command_selector;
  logic [23:0] cmd_data;
  logic [7:0]  status_byte_field;
  logic [23:0] returned_data_bytes;
  logic        outputs_enabled;
  int          fail_count;
  int          total_checks;
  logic        hb_prev;
  logic        hb_frozen;
  logic [7:0]  st;
  logic [23:0] dat;

  hsc_cmd_check DUT (
    .sys_clk(sys_clk), .resetn(resetn), .scan_strobe(scan_strobe),
    .command_selector(command_selector), .cmd_data(cmd_data),
    .count_pulse(count_pulse), .count_down(count_down),
    .limit_input(limit_input), .marker_input(marker_input),
    .iram_fail(iram_fail), .xram_fail(xram_fail), .rom_fail(rom_fail),
    .ext_supply_bad(ext_supply_bad),
    .status_byte_field(status_byte_field),
    .returned_data_bytes(returned_data_bytes),
    .outputs_enabled(outputs_enabled));

  host_cpu_model host (
    .sys_clk(sys_clk), .scan_strobe(scan_strobe),
    .command_selector(command_selector), .cmd_data(cmd_data),
    .status_byte_field(status_byte_field),
    .returned_data_bytes(returned_data_bytes));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic scan(input logic [7:0] c, input logic [23:0] d);
    host.scan(c, d, st, dat);
    if (hb_frozen) begin
      chk("heartbeat held", {23'h0, hb_prev}, {23'h0, st[0]});
    end else begin
      chk("heartbeat toggle", {23'h0, ~hb_prev}, {23'h0, st[0]});
    end
    hb_prev = st[0];
  endtask

  task automatic err(input logic [7:0] c, input logic [23:0] d,
                     input logic [7:0] num);
    scan(c, d);
    chk("type err", {21'h0, hsc_cmd_pkg::TYPE_ERR}, {21'h0, st[7:5]});
    chk("error number", {16'h0000, num}, dat);
  endtask

  task automatic okv(input logic [7:0] c, input logic [23:0] d,
                     input logic [23:0] exp);
    scan(c, d);
    chk("type acc", {21'h0, hsc_cmd_pkg::TYPE_ACC}, {21'h0, st[7:5]});
    chk("accumulator", exp, dat);
  endtask

  task automatic pulse(input int n, ref logic sig);
    @(posedge sys_clk);
    #2;
    sig = 1'b1;
    repeat (n) @(posedge sys_clk);
    #2;
    sig = 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_powerup();
    chk("reset status", 24'h000002, {16'h0, status_byte_field});
    err(hsc_cmd_pkg::CMD_UCL, 24'd1000, hsc_cmd_pkg::ERR_PU);
    err(8'h3F, 24'd0, hsc_cmd_pkg::ERR_PU);
    scan(hsc_cmd_pkg::CMD_CLR_PU, 24'd0);
    chk("pu flag shown", 24'h1, {23'h0, st[1]});
    okv(hsc_cmd_pkg::CMD_LOAD_ACC, 24'hFFFFFB, 24'h000000);
    chk("pu flag", 24'h0, {23'h0, st[1]});
    okv(hsc_cmd_pkg::CMD_DISCRETE, 24'h0, 24'hFFFFFB);
  endtask

  task automatic t_limits();
    okv(hsc_cmd_pkg::CMD_UCL, 24'd1000, 24'hFFFFFB);
    err(hsc_cmd_pkg::CMD_LCL, 24'd874, hsc_cmd_pkg::ERR_LCL);
    okv(hsc_cmd_pkg::CMD_LCL, 24'd873, 24'hFFFFFB);
    err(hsc_cmd_pkg::CMD_UCL, 24'd1000, hsc_cmd_pkg::ERR_UCL);
    okv(hsc_cmd_pkg::CMD_UCL, 24'd1001, 24'hFFFFFB);
    err(hsc_cmd_pkg::CMD_HOME, 24'd872, hsc_cmd_pkg::ERR_HOME);
    for (int i = 0; i < 4; i++) begin
      err(hsc_cmd_pkg::CMD_OUT_PRE + i[7:0], 24'd1002,
          hsc_cmd_pkg::ERR_OUT_PRE + i[7:0]);
    end
    for (int i = 0; i < 8; i++) begin
      err(hsc_cmd_pkg::CMD_INT_PRE + i[7:0], 24'd872,
          hsc_cmd_pkg::ERR_INT_PRE + i[7:0]);
    end
    okv(hsc_cmd_pkg::CMD_INT_PRE, 24'd873, 24'hFFFFFB);
    okv(hsc_cmd_pkg::CMD_INT_PRE + 8'h01, 24'd1001, 24'hFFFFFB);
    err(hsc_cmd_pkg::CMD_LOAD_ACC, 24'd1002, hsc_cmd_pkg::ERR_ACC);
    okv(hsc_cmd_pkg::CMD_LOAD_ACC, 24'd873, 24'hFFFFFB);
    err(hsc_cmd_pkg::CMD_TBASE, 24'h000000, hsc_cmd_pkg::ERR_TBASE);
    err(hsc_cmd_pkg::CMD_TBASE, 24'h010000, hsc_cmd_pkg::ERR_TBASE);
    okv(hsc_cmd_pkg::CMD_TBASE, 24'h00FFFF, 24'd873);
  endtask

  task automatic t_keep_count();
    okv(hsc_cmd_pkg::CMD_DISCRETE, 24'h000003, 24'd873);
    pulse(3, count_pulse);
    err(hsc_cmd_pkg::CMD_LCL, 24'd2000, hsc_cmd_pkg::ERR_LCL);
    chk("count enabled", 24'h1, {23'h0, st[3]});
    chk("outputs on", 24'h1, {23'h0, outputs_enabled});
    okv(hsc_cmd_pkg::CMD_DISCRETE, 24'h000003, 24'd876);
    count_down = 1'b1;
    pulse(2, count_pulse);
    count_down = 1'b0;
  endtask

  task automatic t_home();
    okv(hsc_cmd_pkg::CMD_HOME, 24'd900, 24'd874);
    chk("outputs off", 24'h0, {23'h0, outputs_enabled});
    pulse(3, count_pulse);
    pulse(1, marker_input);
    okv(hsc_cmd_pkg::CMD_TBASE, 24'd1, 24'd874);
    chk("home bit", 24'h0, {23'h0, st[4]});
    pulse(2, limit_input);
    pulse(1, marker_input);
    okv(hsc_cmd_pkg::CMD_TBASE, 24'd1, 24'd900);
    chk("home bit", 24'h1, {23'h0, st[4]});
    chk("outputs still off", 24'h0, {23'h0, outputs_enabled});
    pulse(2, count_pulse);
    okv(hsc_cmd_pkg::CMD_DISCRETE, 24'h000003, 24'd902);
    chk("outputs back on", 24'h1, {23'h0, outputs_enabled});
  endtask

  task automatic t_supply();
    ext_supply_bad = 1'b1;
    err(hsc_cmd_pkg::CMD_TBASE, 24'd1, hsc_cmd_pkg::ERR_SUPPLY);
    chk("supply bit", 24'h1, {23'h0, st[2]});
    err(hsc_cmd_pkg::CMD_TBASE, 24'd1, hsc_cmd_pkg::ERR_PU);
    ext_supply_bad = 1'b0;
    scan(hsc_cmd_pkg::CMD_CLR_PU, 24'd0);
    okv(hsc_cmd_pkg::CMD_LOAD_ACC, 24'hFFFFFB, 24'h000000);
    okv(hsc_cmd_pkg::CMD_RESET, 24'd0, 24'hFFFFFB);
    chk("pu after reset", 24'h1, {23'h0, st[1]});
    err(hsc_cmd_pkg::CMD_TBASE, 24'd1, hsc_cmd_pkg::ERR_PU);
    scan(hsc_cmd_pkg::CMD_CLR_PU, 24'd0);
    okv(hsc_cmd_pkg::CMD_DISCRETE, 24'h0, 24'h000000);
  endtask

  task automatic t_selftest();
    iram_fail = 1'b1;
    hb_frozen = 1'b1;
    err(hsc_cmd_pkg::CMD_TBASE, 24'd1, hsc_cmd_pkg::ERR_IRAM);
    scan(hsc_cmd_pkg::CMD_DISCRETE, 24'h000003);
    chk("dead outputs", 24'h0, {23'h0, outputs_enabled});
    scan(hsc_cmd_pkg::CMD_DISCRETE, 24'h0);
    chk("dead counting", 24'h0, {23'h0, st[3]});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    fail_count = 0;
    total_checks = 0;
    hb_prev = 1'b0;
    hb_frozen = 1'b0;
    resetn = 1'b0;
    {count_pulse, count_down, limit_input, marker_input} = 4'h0;
    {iram_fail, xram_fail, rom_fail, ext_supply_bad} = 4'h0;
    repeat (12) @(posedge sys_clk);
    #2;
    resetn = 1'b1;
    repeat (4) @(posedge sys_clk);
    t_powerup();
    t_limits();
    t_keep_count();
    t_home();
    t_supply();
    t_selftest();
    summarize();
  end
endmodule // testbench
